/* File: acc_analog_model.sv */
// Far-side model: analog sources behind the channel mux and the hardware trigger
`timescale 1ns/10ps
module acc_analog_model (
	input  wire logic         clock,
	input  acc_pkg::acc_mux_t mux,
	output logic [11:0]       sampleResult,
	output logic              hwTriggerInput
);
	logic toggle_q = 1'b0;

	// ==========================================
	// Sources
	// Isolated input floats: a changing pattern keeps a stale value from passing
	always_ff @(posedge clock) toggle_q <= ~toggle_q;
	always_comb begin
		if (mux.muxEnable) sampleResult = {mux.muxCode, 7'h55};
		else if (mux.refHigh) sampleResult = 12'hfff;
		else if (mux.refLow) sampleResult = 12'h000;
		else sampleResult = toggle_q ? 12'ha5a : 12'h5a5;
	end

	// ==========================================
	// Trigger
	initial hwTriggerInput = 1'b0;
	task automatic fire();
		@(posedge clock);
		hwTriggerInput <= 1'b1;
		repeat (3) @(posedge clock);
		hwTriggerInput <= 1'b0;
	endtask
endmodule

/* File: acc_channel_decode.sv */
// Channel select decoder: maps the select code onto mux and reference controls
`timescale 1ns/10ps
module acc_channel_decode (
	input  wire logic [4:0]       channel,
	input  wire logic             active,
	output acc_pkg::acc_mux_t     mux
);

	// ==========================================================
	// Decode
	always_comb begin
		mux = '0;
		mux.muxCode = channel;
		if (active && channel <= acc_pkg::CH_LAST_INPUT) begin // [R1] [R10]
			mux.muxEnable = 1'b1;
		end
		if (active && channel == acc_pkg::CH_REF_HIGH) begin // [R10]
			mux.refHigh = 1'b1;
		end
		if (active && channel == acc_pkg::CH_REF_LOW) begin // [R10]
			mux.refLow = 1'b1;
		end
		// Reserved code powers the converter but connects nothing
		mux.converterOn = active && channel != acc_pkg::CH_DISABLED; // [R11]
	end

endmodule

/* File: acc_conversion_control.sv */
// Conversion control for a successive-approximation converter, APB slave
// Functional notes
// (R1) Select one of up to 28 analog inputs via channel select field.
// (R2) Any control write aborts conversion and starts anew unless channel is all ones. With trigger select set, the code only arms the wait state.
// (R3) Compare off: done flag bit 7 sets on every completion.
// (R4) Compare on: done flag sets only when compare condition is true.
// (R5) Done flag clears on control write or low result byte read.
// (R6) Done flag set with irq enable bit 6 high raises interrupt.
// (R7) Continuous off: one conversion per write or per hardware trigger.
// (R8) Continuous on, software trigger: back-to-back conversions after a write.
// (R9) Continuous on, hardware trigger: continuous conversions start on trigger event.
// (R10) Codes 0-27 inputs, 28 reserved, 29 high ref, 30 low ref.
// (R11) All-ones channel code turns converter off and isolates input.
// (R12) Stopping via all-ones code performs no extra conversion.
// (R13) Single mode returns to low power after each completion.
// (R14) Trigger select bit chooses software or hardware start.
// (R15) Active status bit set on start, cleared on completion or abort.
// (R16) Compare enable bit turns compare on or off.
// (R17) Compare true when less than, or greater-equal if direction bit set.
// (R18) Interrupt stays high while done flag and irq enable are set.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/10ps
module acc_conversion_control #(
	parameter int CONV_CYCLES = acc_pkg::CONV_CYCLES
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             clockEnable,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [7:0]       paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             hwTriggerInput,
	input  wire logic [11:0]      sampleResult,
	output acc_pkg::acc_mux_t     mux,
	output logic                  conversionIrq,
	output logic                  irq
);

	// ==========================================================
	// Trigger synchroniser and edge detect
	logic trigMeta_q;
	logic trigSync_q;
	logic trigPrev_q;
	logic trigEvent;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			trigMeta_q <= 1'b0;
			trigSync_q <= 1'b0;
			trigPrev_q <= 1'b0;
		end else if (clockEnable) begin
			trigMeta_q <= hwTriggerInput;
			trigSync_q <= trigMeta_q;
			trigPrev_q <= trigSync_q;
		end
	end

	assign trigEvent = trigSync_q && !trigPrev_q;

	// ==========================================================
	// Bus decode
	logic access;
	logic wrCtrl;
	logic wrCfg;
	logic wrCmp;
	logic wrIrqSt;
	logic wrIrqMask;
	logic rdResLow;
	logic mapped;

	assign pready    = 1'b1;
	assign access    = psel && penable && clockEnable;
	assign mapped    = paddr inside {acc_pkg::OFF_STATUS_CONTROL, acc_pkg::OFF_TRIGGER_COMPARE,
		acc_pkg::OFF_RESULT_LOW, acc_pkg::OFF_RESULT_HIGH, acc_pkg::OFF_COMPARE_VALUE,
		acc_pkg::OFF_IRQ_STATUS, acc_pkg::OFF_IRQ_MASK};
	assign pslverr   = psel && penable && !mapped;
	assign wrCtrl    = access && pwrite && paddr == acc_pkg::OFF_STATUS_CONTROL;
	assign wrCfg     = access && pwrite && paddr == acc_pkg::OFF_TRIGGER_COMPARE;
	assign wrCmp     = access && pwrite && paddr == acc_pkg::OFF_COMPARE_VALUE;
	assign wrIrqSt   = access && pwrite && paddr == acc_pkg::OFF_IRQ_STATUS;
	assign wrIrqMask = access && pwrite && paddr == acc_pkg::OFF_IRQ_MASK;
	assign rdResLow  = access && !pwrite && paddr == acc_pkg::OFF_RESULT_LOW;

	// ==========================================================
	// Conversion sequencer
	acc_pkg::acc_ctrl_t  ctrl_q, ctrl_d;
	acc_pkg::acc_cfg_t   cfg_q, cfg_d;
	acc_pkg::acc_state_t state_q, state_d;
	logic [15:0]         count_q, count_d;
	logic [11:0]         result_q, result_d;
	logic                done_q, done_d;
	logic                complete;
	logic                cmpTrue;
	logic                startReq;
	logic                abortEvt;

	assign complete = state_q == acc_pkg::ST_CONV && count_q == 16'(CONV_CYCLES - 1);
	// Direction bit picks less-than or greater-or-equal
	assign cmpTrue  = cfg_q.compareGreaterEqual ? (sampleResult >= cfg_q.compareValue)
		: (sampleResult < cfg_q.compareValue); // [R17]
	assign abortEvt = wrCtrl && state_q == acc_pkg::ST_CONV;

	always_comb begin
		ctrl_d   = ctrl_q;
		cfg_d    = cfg_q;
		state_d  = state_q;
		count_d  = count_q;
		result_d = result_q;
		done_d   = done_q;
		startReq = 1'b0;
		if (wrCfg) begin
			cfg_d.triggerSelect       = pwdata[acc_pkg::BIT_TRIGGER_SEL]; // [R14]
			cfg_d.compareEnable       = pwdata[acc_pkg::BIT_COMPARE_EN]; // [R16]
			cfg_d.compareGreaterEqual = pwdata[acc_pkg::BIT_COMPARE_GE];
		end
		if (wrCmp) begin
			cfg_d.compareValue = pwdata[11:0];
		end
		// Hardware start only from the armed wait state, so software mode ignores the pin
		if (cfg_q.triggerSelect && trigEvent && state_q == acc_pkg::ST_WAIT) begin // [R14] [R9]
			startReq = 1'b1;
		end
		// Result read clears first, so a completion in the same cycle still sets the flag
		if (rdResLow) begin
			done_d = 1'b0; // [R5]
		end
		unique case (state_q)
			acc_pkg::ST_IDLE: begin
				// Low-power idle: only a control write leaves it
				state_d = acc_pkg::ST_IDLE;
			end
			acc_pkg::ST_CONV: begin
				count_d = count_q + 16'h0001;
				if (complete) begin
					count_d = '0;
					if (!cfg_q.compareEnable || cmpTrue) begin // [R3] [R4]
						done_d   = 1'b1;
						result_d = sampleResult;
					end
					if (ctrl_q.continuousConvert) begin
						state_d = acc_pkg::ST_CONV; // [R8] [R9]
					end else if (cfg_q.triggerSelect) begin
						state_d = acc_pkg::ST_WAIT; // [R7] [R13]
					end else begin
						state_d = acc_pkg::ST_IDLE; // [R7] [R13]
					end
				end
			end
			acc_pkg::ST_WAIT: begin
				// Converter stays powered down until the next trigger event
				if (startReq) begin
					state_d = acc_pkg::ST_CONV; // [R9] [R15]
					count_d = '0;
				end
			end
			default: state_d = acc_pkg::ST_IDLE;
		endcase
		if (wrCtrl) begin
			ctrl_d.doneIrqEnable      = pwdata[acc_pkg::BIT_DONE_IRQ_EN];
			ctrl_d.continuousConvert  = pwdata[acc_pkg::BIT_CONTINUOUS];
			ctrl_d.inputChannelSelect = pwdata[4:0];
			done_d  = 1'b0; // [R5]
			count_d = '0;
			if (pwdata[4:0] == acc_pkg::CH_DISABLED) begin
				state_d = acc_pkg::ST_IDLE; // [R11] [R12]
			end else if (cfg_q.triggerSelect) begin
				state_d = acc_pkg::ST_WAIT; // [R2] [R14]
			end else begin
				state_d = acc_pkg::ST_CONV; // [R2] [R7]
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_q   <= '{doneIrqEnable: 1'b0, continuousConvert: 1'b0,
				inputChannelSelect: acc_pkg::RST_CHANNEL};
			cfg_q    <= '0;
			state_q  <= acc_pkg::ST_IDLE;
			count_q  <= '0;
			result_q <= '0;
			done_q   <= 1'b0;
		end else if (clockEnable) begin
			ctrl_q   <= ctrl_d;
			cfg_q    <= cfg_d;
			state_q  <= state_d;
			count_q  <= count_d;
			result_q <= result_d;
			done_q   <= done_d;
		end
	end

	// ==========================================================
	// Sticky interrupt status
	logic [1:0] irqSt_q, irqSt_d;
	logic [1:0] irqMask_q, irqMask_d;
	logic [1:0] irqEvt;

	assign irqEvt = {abortEvt, complete && (!cfg_q.compareEnable || cmpTrue)};

	always_comb begin
		irqMask_d = wrIrqMask ? pwdata[1:0] : irqMask_q;
		// Set wins over a write-one clear in the same cycle
		irqSt_d   = (irqSt_q & ~(wrIrqSt ? pwdata[1:0] : 2'h0)) | irqEvt;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irqSt_q   <= '0;
			irqMask_q <= acc_pkg::RST_IRQ_MASK;
		end else if (clockEnable) begin
			irqSt_q   <= irqSt_d;
			irqMask_q <= irqMask_d;
		end
	end

	assign irq           = |(irqSt_q & irqMask_q);
	assign conversionIrq = done_q && ctrl_q.doneIrqEnable; // [R6] [R18]

	// ==========================================================
	// Read data
	logic [31:0] rdData_d;

	always_comb begin
		rdData_d = '0;
		unique case (paddr)
			acc_pkg::OFF_STATUS_CONTROL:  rdData_d[7:0]  = {done_q, ctrl_q};
			// Waiting for a trigger is not a conversion in progress
			acc_pkg::OFF_TRIGGER_COMPARE: rdData_d[7:0]  = {state_q == acc_pkg::ST_CONV, // [R15]
				cfg_q.triggerSelect, cfg_q.compareEnable, cfg_q.compareGreaterEqual, 4'h0};
			acc_pkg::OFF_RESULT_LOW:      rdData_d[7:0]  = result_q[7:0];
			acc_pkg::OFF_RESULT_HIGH:     rdData_d[3:0]  = result_q[11:8];
			acc_pkg::OFF_COMPARE_VALUE:   rdData_d[11:0] = cfg_q.compareValue;
			acc_pkg::OFF_IRQ_STATUS:      rdData_d[1:0]  = irqSt_q;
			acc_pkg::OFF_IRQ_MASK:        rdData_d[1:0]  = irqMask_q;
			default:                      rdData_d       = '0;
		endcase
	end

	// Loaded in the setup cycle so the access phase needs no wait state
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prdata <= '0;
		end else if (clockEnable && psel && !penable && !pwrite) begin
			prdata <= rdData_d;
		end
	end

	// ==========================================================
	// Channel mux
	acc_channel_decode u_decode (
		.channel (ctrl_q.inputChannelSelect),
		.active  (state_q == acc_pkg::ST_CONV),
		.mux     (mux)
	);

	// ==========================================================
	// Checks
	sequence S_CTRL_WRITE_GO;
		wrCtrl && pwdata[4:0] != acc_pkg::CH_DISABLED && !cfg_q.triggerSelect;
	endsequence

	AST_WRITE_STARTS: assert property (@(posedge clock) disable iff (rst) // [R2]
		S_CTRL_WRITE_GO |=> state_q == acc_pkg::ST_CONV && count_q == '0)
		else $error("Control write did not restart conversion");
	AST_DISABLE_STOPS: assert property (@(posedge clock) disable iff (rst) // [R11] [R12]
		wrCtrl && pwdata[4:0] == acc_pkg::CH_DISABLED |=> state_q == acc_pkg::ST_IDLE && !mux.converterOn)
		else $error("All-ones code did not stop converter");
	sequence S_SINGLE_END;
		clockEnable && complete && !ctrl_q.continuousConvert && !wrCtrl;
	endsequence

	sequence S_CONT_END;
		clockEnable && complete && ctrl_q.continuousConvert && !wrCtrl;
	endsequence

	AST_DONE_SETS: assert property (@(posedge clock) disable iff (rst) // [R3]
		clockEnable && complete && !cfg_q.compareEnable && !wrCtrl |=> done_q)
		else $error("Done flag not set on completion");
	AST_CMP_GATES: assert property (@(posedge clock) disable iff (rst) // [R4]
		clockEnable && !done_q && complete && cfg_q.compareEnable && !cmpTrue |=> !done_q)
		else $error("Done flag set despite failed compare");
	AST_CLEAR_ON_WRITE: assert property (@(posedge clock) disable iff (rst) // [R5]
		wrCtrl || (rdResLow && !complete) |=> !done_q)
		else $error("Done flag not cleared");
	AST_IRQ_RISE: assert property (@(posedge clock) disable iff (rst) // [R6]
		clockEnable && complete && (!cfg_q.compareEnable || cmpTrue) && ctrl_q.doneIrqEnable && !wrCtrl
		|=> conversionIrq)
		else $error("Interrupt not raised on completion");
	AST_IRQ_LEVEL: assert property (@(posedge clock) disable iff (rst) // [R18]
		conversionIrq && !wrCtrl && !rdResLow |=> conversionIrq)
		else $error("Interrupt level dropped");
	AST_SINGLE_IDLE: assert property (@(posedge clock) disable iff (rst) // [R13]
		S_SINGLE_END |=> state_q != acc_pkg::ST_CONV && !mux.converterOn)
		else $error("Single mode did not return to low power");
	AST_SINGLE_ONE: assert property (@(posedge clock) disable iff (rst) // [R7]
		S_SINGLE_END ##1 (!wrCtrl && !trigEvent) |=> state_q != acc_pkg::ST_CONV)
		else $error("Single mode started an extra conversion");
	AST_IDLE_HOLDS: assert property (@(posedge clock) disable iff (rst) // [R14]
		clockEnable && state_q == acc_pkg::ST_IDLE && !wrCtrl |=> state_q == acc_pkg::ST_IDLE)
		else $error("Idle left without a control write");
	AST_HW_START: assert property (@(posedge clock) disable iff (rst) // [R9]
		clockEnable && state_q == acc_pkg::ST_WAIT && cfg_q.triggerSelect && trigEvent && !wrCtrl
		|=> state_q == acc_pkg::ST_CONV && count_q == '0)
		else $error("Trigger event did not start conversion");
	AST_CONT_SW: assert property (@(posedge clock) disable iff (rst) // [R8]
		S_CONT_END ##0 !cfg_q.triggerSelect
		|=> state_q == acc_pkg::ST_CONV && count_q == '0)
		else $error("Continuous conversion did not restart");
	AST_CONT_HW: assert property (@(posedge clock) disable iff (rst) // [R9]
		S_CONT_END ##0 cfg_q.triggerSelect
		|=> state_q == acc_pkg::ST_CONV && count_q == '0)
		else $error("Triggered continuous conversion did not repeat");
	AST_MUX_INPUT: assert property (@(posedge clock) disable iff (rst) // [R1] [R10]
		state_q == acc_pkg::ST_CONV && ctrl_q.inputChannelSelect <= acc_pkg::CH_LAST_INPUT
		|-> mux.muxEnable && mux.muxCode == ctrl_q.inputChannelSelect && !mux.refHigh && !mux.refLow)
		else $error("Analog input not connected");
	AST_MUX_REF: assert property (@(posedge clock) disable iff (rst) // [R10]
		state_q == acc_pkg::ST_CONV && ctrl_q.inputChannelSelect == acc_pkg::CH_REF_LOW
		|-> mux.refLow && !mux.refHigh && !mux.muxEnable)
		else $error("Low reference not selected");
	AST_ISOLATED: assert property (@(posedge clock) disable iff (rst) // [R11]
		state_q != acc_pkg::ST_CONV |-> !mux.converterOn && !mux.muxEnable && !mux.refHigh && !mux.refLow)
		else $error("Input not isolated outside conversion");

endmodule

/* File: acc_conversion_control_tb.sv */
// Self-checking testbench for the conversion control block
`timescale 1ns/10ps
module acc_conversion_control_tb;
	logic clock, rst, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, hwTriggerInput, conversionIrq, irq, lastErr, done;
	logic [11:0] sampleResult;
	acc_pkg::acc_mux_t mux;
	int errors = 0;
	int checked = 0;

	acc_conversion_control #(.CONV_CYCLES(4)) dut_u (.clock(clock), .rst(rst), .clockEnable(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .hwTriggerInput(hwTriggerInput),
		.sampleResult(sampleResult), .mux(mux), .conversionIrq(conversionIrq), .irq(irq));
	acc_analog_model model_u (.clock(clock), .mux(mux), .sampleResult(sampleResult),
		.hwTriggerInput(hwTriggerInput));

	// ==========================================
	// Helpers
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic finish_test();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	// Master holds the request until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errors++;
			finish_test();
		end
		rd = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge: the next call never drives psel twice in one step, and writes have landed
		@(posedge clock);
	endtask

	// Polls the done flag for a bounded number of reads
	task automatic poll_done();
		done = 1'b0;
		for (int i = 0; i < 12 && done !== 1'b1; i++) begin
			apb(1'b0, acc_pkg::OFF_STATUS_CONTROL, 32'h0);
			done = rd[7];
		end
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset();
		apb(1'b0, acc_pkg::OFF_STATUS_CONTROL, 32'h0);
		chk("ctrl reset", 32'h0000001f, rd);
		chk("converter off", 32'h0, {31'h0, mux.converterOn});
		apb(1'b0, 8'h1c, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, lastErr});
		$display("test reset done");
	endtask

	task automatic t_single();
		apb(1'b1, acc_pkg::OFF_IRQ_MASK, 32'h1);
		apb(1'b1, acc_pkg::OFF_STATUS_CONTROL, 32'h43);
		chk("mux code", 32'h3, {27'h0, mux.muxCode});
		chk("mux enable", 32'h1, {31'h0, mux.muxEnable});
		apb(1'b1, acc_pkg::OFF_STATUS_CONTROL, 32'h43);
		poll_done();
		chk("done", 32'h1, {31'h0, done});
		chk("conv irq", 32'h1, {31'h0, conversionIrq});
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'b0, acc_pkg::OFF_IRQ_STATUS, 32'h0);
		chk("irq status", 32'h3, rd);
		apb(1'b0, acc_pkg::OFF_TRIGGER_COMPARE, 32'h0);
		chk("active", 32'h0, {31'h0, rd[7]});
		chk("idle power", 32'h0, {31'h0, mux.converterOn});
		apb(1'b1, acc_pkg::OFF_IRQ_STATUS, 32'h1);
		chk("irq clear", 32'h0, {31'h0, irq});
		chk("irq level", 32'h1, {31'h0, conversionIrq});
		apb(1'b0, acc_pkg::OFF_RESULT_LOW, 32'h0);
		chk("result low", 32'hd5, rd);
		chk("irq drop", 32'h0, {31'h0, conversionIrq});
		poll_done();
		chk("one only", 32'h0, {31'h0, done});
		$display("test single done");
	endtask

	task automatic t_refs();
		apb(1'b1, acc_pkg::OFF_STATUS_CONTROL, 32'h1d);
		chk("ref high", 32'h1, {31'h0, mux.refHigh});
		apb(1'b1, acc_pkg::OFF_STATUS_CONTROL, 32'h1e);
		chk("ref low", 32'h1, {31'h0, mux.refLow});
		poll_done();
		$display("test refs done");
	endtask

	task automatic t_compare();
		apb(1'b1, acc_pkg::OFF_COMPARE_VALUE, 32'h1d5);
		apb(1'b1, acc_pkg::OFF_TRIGGER_COMPARE, 32'h20);
		apb(1'b1, acc_pkg::OFF_STATUS_CONTROL, 32'h03);
		poll_done();
		chk("lt equal", 32'h0, {31'h0, done});
		apb(1'b1, acc_pkg::OFF_TRIGGER_COMPARE, 32'h30);
		apb(1'b1, acc_pkg::OFF_STATUS_CONTROL, 32'h03);
		poll_done();
		chk("ge equal", 32'h1, {31'h0, done});
		apb(1'b1, acc_pkg::OFF_TRIGGER_COMPARE, 32'h0);
		$display("test compare done");
	endtask

	task automatic t_continuous();
		apb(1'b1, acc_pkg::OFF_STATUS_CONTROL, 32'h25);
		poll_done();
		apb(1'b0, acc_pkg::OFF_RESULT_LOW, 32'h0);
		chk("cont low", 32'h000000d5, rd);
		poll_done();
		chk("again", 32'h1, {31'h0, done});
		apb(1'b1, acc_pkg::OFF_STATUS_CONTROL, 32'h3f);
		chk("off", 32'h0, {31'h0, mux.converterOn});
		apb(1'b0, acc_pkg::OFF_TRIGGER_COMPARE, 32'h0);
		chk("abort act", 32'h0, {31'h0, rd[7]});
		poll_done();
		chk("no extra", 32'h0, {31'h0, done});
		$display("test continuous done");
	endtask

	task automatic t_hw();
		apb(1'b1, acc_pkg::OFF_TRIGGER_COMPARE, 32'h40);
		apb(1'b1, acc_pkg::OFF_STATUS_CONTROL, 32'h02);
		poll_done();
		chk("hw wait", 32'h0, {31'h0, done});
		model_u.fire();
		poll_done();
		chk("hw done", 32'h1, {31'h0, done});
		apb(1'b0, acc_pkg::OFF_RESULT_LOW, 32'h0);
		chk("hw result", 32'h00000055, rd);
		poll_done();
		chk("hw one", 32'h0, {31'h0, done});
		apb(1'b1, acc_pkg::OFF_STATUS_CONTROL, 32'h22);
		model_u.fire();
		poll_done();
		chk("hw cont", 32'h1, {31'h0, done});
		apb(1'b0, acc_pkg::OFF_RESULT_LOW, 32'h0);
		poll_done();
		chk("hw repeat", 32'h1, {31'h0, done});
		$display("test hw done");
	endtask

	// ==========================================
	// Main
	initial begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_reset();
		t_single();
		t_refs();
		t_compare();
		t_continuous();
		t_hw();
		finish_test();
	end
endmodule

/* File: acc_pkg.sv */
// Package: register map, field layout and types for conversion control
package acc_pkg;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_STATUS_CONTROL  = 8'h00;
	localparam logic [7:0] OFF_TRIGGER_COMPARE = 8'h04;
	localparam logic [7:0] OFF_RESULT_LOW      = 8'h08;
	localparam logic [7:0] OFF_RESULT_HIGH     = 8'h0c;
	localparam logic [7:0] OFF_COMPARE_VALUE   = 8'h10;
	localparam logic [7:0] OFF_IRQ_STATUS      = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK        = 8'h18;

	// ==========================================================
	// Field positions
	localparam int BIT_DONE_FLAG    = 7;
	localparam int BIT_DONE_IRQ_EN  = 6;
	localparam int BIT_CONTINUOUS   = 5;
	localparam int BIT_ACTIVE       = 7;
	localparam int BIT_TRIGGER_SEL  = 6;
	localparam int BIT_COMPARE_EN   = 5;
	localparam int BIT_COMPARE_GE   = 4;
	localparam int IRQ_BIT_DONE     = 0;
	localparam int IRQ_BIT_ABORT    = 1;

	// ==========================================================
	// Channel codes and reset values
	localparam logic [4:0] CH_LAST_INPUT = 5'h1b;
	localparam logic [4:0] CH_RESERVED   = 5'h1c;
	localparam logic [4:0] CH_REF_HIGH   = 5'h1d;
	localparam logic [4:0] CH_REF_LOW    = 5'h1e;
	localparam logic [4:0] CH_DISABLED   = 5'h1f;
	localparam logic [4:0] RST_CHANNEL   = 5'h1f;
	localparam logic [1:0] RST_IRQ_MASK  = 2'h0;

	// ==========================================================
	// Timing
	localparam int CONV_TIME_NS  = 100;
	localparam int CLK_PERIOD_NS = 4;
	localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ==========================================================
	// Types
	typedef struct packed {
		logic       doneIrqEnable;
		logic       continuousConvert;
		logic [4:0] inputChannelSelect;
	} acc_ctrl_t;

	typedef struct packed {
		logic        triggerSelect;
		logic        compareEnable;
		logic        compareGreaterEqual;
		logic [11:0] compareValue;
	} acc_cfg_t;

	typedef struct packed {
		logic       muxEnable;
		logic [4:0] muxCode;
		logic       refHigh;
		logic       refLow;
		logic       converterOn;
	} acc_mux_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CONV = 3'b010,
		ST_WAIT = 3'b100
	} acc_state_t;

endpackage
